/* File: pll_cfg_pkg.sv */
// Purpose: Shared constants for the PLL configuration register decode
// Assumes: Eight register bytes, byte address 0..7, cleared at power-up
// Notes:   Bit positions are absolute positions in the 64-bit image
package pll_cfg_pkg;
    localparam int unsigned NUM_BYTES          = 8;
    localparam int unsigned ADDR_W             = 3;
    localparam logic [7:0]  BYTE_RESET         = 8'h00;
    localparam logic [2:0]  OFS_INPUT_DIV_LOW  = 3'h0;
    localparam logic [2:0]  OFS_SRC_DIV_HIGH   = 3'h1;
    localparam logic [2:0]  OFS_POST_DIV_SEL   = 3'h2;
    localparam logic [2:0]  OFS_LOOP_DIV_LOW   = 3'h3;
    localparam int unsigned POS_INPUT_DIV_LSB  = 0;
    localparam int unsigned INPUT_DIV_W        = 12;
    localparam int unsigned POS_INPUT_SRC      = 12;
    localparam int unsigned POS_SHUTDOWN       = 13;
    localparam int unsigned POS_DET_FIRST      = 14;
    localparam int unsigned POS_DET_RETURN     = 15;
    localparam int unsigned POS_POST_ONE_LSB   = 16;
    localparam int unsigned POS_POST_TWO_LSB   = 18;
    localparam int unsigned POS_POST_THREE_LSB = 20;
    localparam int unsigned POS_LOOP_DIV_LSB   = 24;
    localparam int unsigned LOOP_DIV_W         = 14;
    localparam int unsigned A_COUNT_W          = 3;
    localparam int unsigned POS_LOOP_SRC_LSB   = 38;
    localparam int unsigned POS_OFF_CHIP_FILT  = 42;
    localparam int unsigned POS_OSC_VARIANT    = 45;
    localparam int unsigned POS_OUT_SEL_LSB    = 46;
    localparam int unsigned POS_PHASE_DELAY    = 48;
    localparam int unsigned POS_SINGLE_ENDED   = 60;
    localparam int unsigned POS_IND_MODE_LSB   = 62;

    typedef enum logic [1:0] {
        OUT_MAIN_OSC, OUT_INPUT_DIV, OUT_DET_INPUT, OUT_CRYSTAL_OSC
    } out_sel_t;
    typedef enum logic [1:0] {
        LOOP_POST_OUT, LOOP_RETURN_PIN, LOOP_OSC_OUT, LOOP_RETURN_PIN_ALT
    } loop_src_t;
    typedef enum logic [1:0] {
        IND_XTAL_LOCK, IND_XTAL_RANGE, IND_MAIN_PHASE, IND_LOOP_DIV
    } ind_mode_t;
endpackage

/* File: pll_config_register_decode.sv */
// Purpose: Register file and decode of the PLL configuration bytes
// Assumes: Serial engine gives one-cycle byte strobe at its acknowledge
// Notes:   Outputs are registered, one cycle after the image changes
`timescale 1ns/1ps
module pll_config_register_decode
    import pll_cfg_pkg::*;
#(
    parameter int unsigned BYTES = pll_cfg_pkg::NUM_BYTES
) (
    input  wire logic                           clk_sys,                 // 20 MHz clock
    input  wire logic                           reset,                   // Async reset
    input  wire logic                           byte_ack,                // Byte acknowledged
    input  wire logic [pll_cfg_pkg::ADDR_W-1:0] byte_addr,               // Register pointer
    input  wire logic [7:0]                     byte_wdata,              // Written byte
    input  wire logic [pll_cfg_pkg::ADDR_W-1:0] read_addr,               // Read pointer
    input  wire logic                           lock_status_in,          // Live lock level
    output logic      [7:0]                     read_data,               // Read byte
    output logic                                main_loop_shutdown,      // Main loop off
    output logic                                input_divider_source,    // 1 = input pin
    output logic                                detector_first_input_select,  // 1 = input pin
    output logic                                detector_return_input_select, // 1 = return pin
    output logic      [11:0]                    input_divider_ratio,     // Input divider
    output logic      [13:0]                    loop_divider_ratio,      // Whole loop field
    output logic      [2:0]                     loop_a_count,            // A-counter
    output logic      [10:0]                    loop_m_count,            // M-counter
    output logic      [3:0]                     post_stage_one_ratio,    // Stage one ratio
    output logic      [3:0]                     post_stage_two_ratio,    // Stage two ratio
    output logic      [3:0]                     post_stage_three_ratio,  // Stage three ratio
    output pll_cfg_pkg::loop_src_t              loop_divider_source,     // Loop divider input
    output logic                                off_chip_filter_select,  // External filter
    output logic                                oscillator_variant,      // 1 = legacy osc
    output pll_cfg_pkg::out_sel_t               output_clock_select,     // Output mux
    output logic                                phase_delay_enable,      // Phase delay on
    output logic                                single_ended_drive,      // 0 = differential
    output logic                                indicator_pin_enable,    // Lock output on
    output pll_cfg_pkg::ind_mode_t              indicator_pin_mode       // Indicator mode
);
    // ==========================================================
    // Register image
    logic [7:0]  regs_q [BYTES];
    logic [63:0] image;
    logic [3:0]  p1_d;
    logic [3:0]  p2_d;
    logic [3:0]  p3_d;

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < BYTES; i++)
                regs_q[i] <= BYTE_RESET;
        end
        else if (byte_ack)
        begin
            regs_q[byte_addr] <= byte_wdata;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : g_image
            assign image[g*8 +: 8] = regs_q[g];
        end
    endgenerate

    // ==========================================================
    // Read back; top bit of byte 7 shows live lock level
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            read_data <= BYTE_RESET;
        else if (read_addr == 3'h7)
            read_data <= {lock_status_in, regs_q[7][6:0]};
        else
            read_data <= regs_q[read_addr];
    end

    // ==========================================================
    // Post-divider stage decode
    post_stage_decode #(.FIRST_STAGE(1'b1)) u_post_one (
        .code  (image[POS_POST_ONE_LSB +: 2]),
        .ratio (p1_d)
    );
    post_stage_decode #(.FIRST_STAGE(1'b0)) u_post_two (
        .code  (image[POS_POST_TWO_LSB +: 2]),
        .ratio (p2_d)
    );
    post_stage_decode #(.FIRST_STAGE(1'b0)) u_post_three (
        .code  (image[POS_POST_THREE_LSB +: 2]),
        .ratio (p3_d)
    );

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            post_stage_one_ratio   <= 4'h1;
            post_stage_two_ratio   <= 4'h1;
            post_stage_three_ratio <= 4'h1;
        end
        else
        begin
            post_stage_one_ratio   <= p1_d;
            post_stage_two_ratio   <= p2_d;
            post_stage_three_ratio <= p3_d;
        end
    end

    // ==========================================================
    // Divider ratios and source selects
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            input_divider_ratio          <= 12'h000;
            loop_divider_ratio           <= 14'h0000;
            loop_a_count                 <= 3'h0;
            loop_m_count                 <= 11'h000;
            input_divider_source         <= 1'b0;
            detector_first_input_select  <= 1'b0;
            detector_return_input_select <= 1'b0;
            main_loop_shutdown           <= 1'b0;
            loop_divider_source          <= LOOP_POST_OUT;
        end
        else
        begin
            input_divider_ratio <= image[POS_INPUT_DIV_LSB +: INPUT_DIV_W];
            loop_divider_ratio  <= image[POS_LOOP_DIV_LSB +: LOOP_DIV_W];
            loop_a_count <= image[POS_LOOP_DIV_LSB +: A_COUNT_W];
            loop_m_count <= image[POS_LOOP_DIV_LSB + A_COUNT_W +: 11];
            input_divider_source         <= image[POS_INPUT_SRC];
            detector_first_input_select  <= image[POS_DET_FIRST];
            detector_return_input_select <= image[POS_DET_RETURN];
            main_loop_shutdown  <= image[POS_SHUTDOWN];
            loop_divider_source <= loop_src_t'(image[POS_LOOP_SRC_LSB +: 2]);
        end
    end

    // ==========================================================
    // Loop, oscillator and output controls
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            off_chip_filter_select <= 1'b0;
            oscillator_variant     <= 1'b0;
            output_clock_select    <= OUT_MAIN_OSC;
            phase_delay_enable     <= 1'b0;
            single_ended_drive     <= 1'b0;
            indicator_pin_enable   <= 1'b0;
            indicator_pin_mode     <= IND_XTAL_LOCK;
        end
        else
        begin
            off_chip_filter_select <= image[POS_OFF_CHIP_FILT];
            oscillator_variant     <= image[POS_OSC_VARIANT];
            output_clock_select <= out_sel_t'(image[POS_OUT_SEL_LSB +: 2]);
            phase_delay_enable  <= image[POS_PHASE_DELAY];
            single_ended_drive   <= image[POS_SINGLE_ENDED];
            indicator_pin_enable <= image[POS_SINGLE_ENDED];
            indicator_pin_mode <= ind_mode_t'(image[POS_IND_MODE_LSB +: 2]);
        end
    end

    // ==========================================================
    // Checks
    shutdown_follow_a: assert property (@(posedge clk_sys) disable iff (reset)
        byte_ack && byte_addr == 3'h1 ##1 1'b1 |=> main_loop_shutdown == $past(byte_wdata[5], 2))
        else $error("shutdown does not follow bit 13");
    out_mux_a: assert property (@(posedge clk_sys) disable iff (reset)
        byte_ack && byte_addr == 3'h5 |->
            ##2 output_clock_select == out_sel_t'($past(byte_wdata[7:6], 2)))
        else $error("output select mismatch");
    loop_src_a: assert property (@(posedge clk_sys) disable iff (reset)
        byte_ack && byte_addr == 3'h4 |->
            ##2 loop_divider_source == loop_src_t'($past(byte_wdata[7:6], 2)))
        else $error("loop source mismatch");
    osc_variant_a: assert property (@(posedge clk_sys) disable iff (reset)
        byte_ack && byte_addr == 3'h5 |-> ##2 oscillator_variant == $past(byte_wdata[5], 2))
        else $error("oscillator variant mismatch");
    ind_mode_a: assert property (@(posedge clk_sys) disable iff (reset)
        byte_ack && byte_addr == 3'h7 |->
            ##2 indicator_pin_mode == ind_mode_t'($past(byte_wdata[7:6], 2)))
        else $error("indicator mode mismatch");
    loop_split_a: assert property (@(posedge clk_sys) disable iff (reset)
        byte_ack && byte_addr == 3'h3 |-> ##2 loop_a_count == $past(byte_wdata[2:0], 2)
            && loop_m_count[4:0] == $past(byte_wdata[7:3], 2))
        else $error("loop divider split wrong");
    phase_delay_a: assert property (@(posedge clk_sys) disable iff (reset)
        byte_ack && byte_addr == 3'h6 |-> ##2 phase_delay_enable == $past(byte_wdata[0], 2))
        else $error("phase delay mismatch");
    filter_sel_a: assert property (@(posedge clk_sys) disable iff (reset)
        byte_ack && byte_addr == 3'h5 |-> ##2 off_chip_filter_select == $past(byte_wdata[2], 2))
        else $error("filter select mismatch");
    post_one_a: assert property (@(posedge clk_sys) disable iff (reset)
        byte_ack && byte_addr == 3'h2 && byte_wdata[1:0] == 2'h3 |->
            ##2 post_stage_one_ratio == 4'h8)
        else $error("post stage one decode wrong");
    in_div_a: assert property (@(posedge clk_sys) disable iff (reset)
        byte_ack && byte_addr == 3'h0 |-> ##2 input_divider_ratio[7:0] == $past(byte_wdata, 2))
        else $error("input divider low byte mismatch");
    byte_store_a: assert property (@(posedge clk_sys) disable iff (reset)
        byte_ack && byte_addr == 3'h0 |=> regs_q[0] == $past(byte_wdata))
        else $error("byte not stored at its acknowledge");
    det_src_a: assert property (@(posedge clk_sys) disable iff (reset)
        byte_ack && byte_addr == 3'h1 |-> ##2 input_divider_source == $past(byte_wdata[4], 2)
            && detector_first_input_select == $past(byte_wdata[6], 2)
            && detector_return_input_select == $past(byte_wdata[7], 2))
        else $error("source select mismatch");
    drive_lock_a: assert property (@(posedge clk_sys) disable iff (reset)
        byte_ack && byte_addr == 3'h7 |-> ##2 single_ended_drive == $past(byte_wdata[4], 2)
            && indicator_pin_enable == $past(byte_wdata[4], 2))
        else $error("drive and indicator enable mismatch");
endmodule

/* File: pll_config_register_decode_tb_top.sv */
// Purpose: Self-checking bench for the PLL configuration decode
// Assumes: Outputs settle two edges after the taking edge
// Notes:   Shadow image holds the expected 64-bit register contents
`timescale 1ns/1ps
module pll_config_register_decode_tb_top;
    import pll_cfg_pkg::*;
    logic        clk_sys, reset, byte_ack, lock_status_in;
    logic [2:0]  byte_addr, read_addr;
    logic [7:0]  byte_wdata, read_data;
    logic        main_loop_shutdown, input_divider_source, off_chip_filter_select;
    logic        detector_first_input_select, detector_return_input_select;
    logic [11:0] input_divider_ratio;
    logic [13:0] loop_divider_ratio;
    logic [2:0]  loop_a_count;
    logic [10:0] loop_m_count;
    logic [3:0]  post_stage_one_ratio, post_stage_two_ratio, post_stage_three_ratio;
    loop_src_t   loop_divider_source;
    out_sel_t    output_clock_select;
    ind_mode_t   indicator_pin_mode;
    logic        oscillator_variant, phase_delay_enable, single_ended_drive;
    logic        indicator_pin_enable;
    logic [63:0] img;
    int          miscompares;
    int          check_count;

    pll_config_register_decode u_pll_config_register_decode (.clk_sys, .reset, .byte_ack,
        .byte_addr, .byte_wdata, .read_addr, .lock_status_in, .read_data, .main_loop_shutdown,
        .input_divider_source, .detector_first_input_select, .detector_return_input_select,
        .input_divider_ratio, .loop_divider_ratio, .loop_a_count, .loop_m_count,
        .post_stage_one_ratio, .post_stage_two_ratio, .post_stage_three_ratio,
        .loop_divider_source, .off_chip_filter_select, .oscillator_variant,
        .output_clock_select, .phase_delay_enable, .single_ended_drive,
        .indicator_pin_enable, .indicator_pin_mode);
    pll_host_model u_pll_host_model (.clk_sys, .byte_ack, .byte_addr, .byte_wdata);

    initial clk_sys = 1'b0;
    always #25 clk_sys = ~clk_sys;

    // ==========================================
    // Expectation and comparison helpers
    function automatic logic [3:0] post_ratio(input logic [1:0] c, input bit first);
        if (first)
            return 4'h1 << c;
        case (c)
            2'h0: return 4'h1;
            2'h1: return 4'h3;
            2'h2: return 4'h5;
            default: return 4'h4;
        endcase
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_all();
        logic [11:0] p;
        p = {post_ratio(img[21:20], 0), post_ratio(img[19:18], 0), post_ratio(img[17:16], 1)};
        chk(main_loop_shutdown, img[13]);
        chk(output_clock_select, img[47:46]);
        chk(loop_divider_source, img[39:38]);
        chk(oscillator_variant, img[45]);
        chk(indicator_pin_mode, img[63:62]);
        chk({loop_m_count, loop_a_count}, img[37:24]);
        chk(loop_divider_ratio, img[37:24]);
        chk(phase_delay_enable, img[48]);
        chk(off_chip_filter_select, img[42]);
        chk({post_stage_three_ratio, post_stage_two_ratio, post_stage_one_ratio}, p);
        chk(input_divider_ratio, img[11:0]);
        chk({detector_return_input_select, detector_first_input_select}, img[15:14]);
        chk(input_divider_source, img[12]);
        chk({indicator_pin_enable, single_ended_drive}, {img[60], img[60]});
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        img[a*8 +: 8] = (a == 3'h2) ? (d & 8'h3f) : d;
        u_pll_host_model.send(a, d);
    endtask
    task automatic settle();
        u_pll_host_model.release_bus();
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic rd(input logic [2:0] a);
        logic [7:0] e;
        read_addr = a;
        e = img[a*8 +: 8];
        if (a == 3'h7)
            e[7] = lock_status_in;
        @(negedge clk_sys);
        chk(read_data, e);
    endtask
    task automatic close_out();
        $display("Comparisons %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ==========================================
    // Main sequence
    initial
    begin
        logic [7:0] d;
        miscompares = 0;
        check_count = 0;
        reset = 1'b1;
        read_addr = 3'h0;
        lock_status_in = 1'b0;
        img = '0;
        d = 8'($urandom(32'h3b14));
        repeat (10) @(negedge clk_sys);
        reset = 1'b0;
        @(negedge clk_sys);
        check_all();
        for (int i = 0; i < 4; i++)
        begin
            d = 8'(i);
            wr(3'h2, {2'b11, d[1:0], d[1:0], d[1:0]});
            wr(3'h4, {d[1:0], 6'h15});
            wr(3'h5, {d[1:0], 6'h2a});
            wr(3'h7, {d[1:0], 6'h10});
            settle();
            check_all();
        end
        for (int i = 0; i < 8; i++)
            wr(3'(i), 8'hff);
        settle();
        check_all();
        for (int i = 0; i < 60; i++)
        begin
            lock_status_in = 1'($urandom);
            wr(3'($urandom_range(7)), 8'($urandom));
            if (i % 3 != 0)
            begin
                settle();
                check_all();
                rd(3'($urandom_range(7)));
            end
        end
        reset = 1'b1;
        img = '0;
        @(negedge clk_sys);
        reset = 1'b0;
        @(negedge clk_sys);
        check_all();
        rd(3'h7);
        close_out();
    end

    initial
    begin
        #(50 * 20000);
        miscompares++;
        close_out();
    end
endmodule

/* File: pll_host_model.sv */
// Purpose: Serial host model handing acknowledged bytes to the decode
// Assumes: One-cycle byte strobe per byte, driven at falling edges
// Notes:   Released lines show the inverse of their last value
`timescale 1ns/1ps
module pll_host_model (
    input  wire logic                           clk_sys,    // System clock
    output logic                                byte_ack,   // Byte strobe
    output logic [pll_cfg_pkg::ADDR_W-1:0]      byte_addr,  // Register pointer
    output logic [7:0]                          byte_wdata  // Byte value
);
    initial
    begin
        byte_ack   = 1'b0;
        byte_addr  = 3'h0;
        byte_wdata = 8'h00;
    end
    // Entered at a falling edge, returns at the next one
    task automatic send(input logic [2:0] addr, input logic [7:0] data);
        byte_ack   = 1'b1;
        byte_addr  = addr;
        byte_wdata = (addr == 3'h2) ? (data & 8'h3f) : data;
        @(negedge clk_sys);
    endtask
    task automatic release_bus();
        byte_ack   = 1'b0;
        byte_addr  = ~byte_addr;
        byte_wdata = ~byte_wdata;
    endtask
endmodule

/* File: post_stage_decode.sv */
// Purpose: Decode one two-bit post-divider stage code into its ratio
// Assumes: Stage one uses the binary table, other stages the 1/3/5/4 table
// Notes:   Combinational
`timescale 1ns/1ps
module post_stage_decode #(
    parameter bit FIRST_STAGE = 1'b0
) (
    input  wire logic [1:0] code,   // Stage select code
    output logic      [3:0] ratio   // Division ratio
);
    always_comb
    begin
        if (FIRST_STAGE)
        begin
            case (code)
                2'h0:    ratio = 4'h1;
                2'h1:    ratio = 4'h2;
                2'h2:    ratio = 4'h4;
                default: ratio = 4'h8;
            endcase
        end
        else
        begin
            case (code)
                2'h0:    ratio = 4'h1;
                2'h1:    ratio = 4'h3;
                2'h2:    ratio = 4'h5;
                default: ratio = 4'h4;
            endcase
        end
    end
endmodule
